// [design/isic_pkg.sv]
package isic_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int DET_W = 3;
    localparam int IRQ_W = 4;
    localparam int CFG_W = 6;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_RATE = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] WORD_MASK = 8'hFC;
    localparam int ST_MASTER = 7;
    localparam int ST_DIR = 6;
    localparam int ST_BUSY = 5;
    localparam int ST_INTMON = 4;
    localparam int ST_ARB = 3;
    localparam int ST_AAS = 2;
    localparam int ST_GC = 1;
    localparam int ST_LRB = 0;
    localparam int DET_ARB = 2;
    localparam int DET_AAS = 1;
    localparam int DET_GC = 0;
    localparam int RATE_ONE = 7;
    localparam int RATE_RUN = 6;
    localparam int IRQ_ARB = 0;
    localparam int IRQ_AAS = 1;
    localparam int IRQ_GC = 2;
    localparam int IRQ_CHAN = 3;
    localparam logic [REG_W-1:0] CTRL2_RESET = 8'h00;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
    localparam logic RUN_RESET = 1'b0;
    localparam logic INTMON_RESET = 1'b1;
    localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        WST_COLLECT = 2'h0,
        WST_COMMIT = 2'h1,
        WST_RESP = 2'h3
    } isic_wstate_type;
    typedef enum logic [1:0] {
        RST_IDLE = 2'h0,
        RST_FETCH = 2'h1,
        RST_RESP = 2'h3
    } isic_rstate_type;
endpackage

// [design/isic_flag_bank.sv]
`timescale 1ns/10ps
module isic_flag_bank #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // A set in the same cycle as a clear wins, so no event is lost.
            always_comb begin
                flags_next[i] = set[i] | (flags_reg[i] & ~clr[i]);
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end
    assign flags = flags_reg;
endmodule // isic_flag_bank

// [design/isic_axil_slave.sv]
`timescale 1ns/10ps
module isic_axil_slave (
    input wire logic clk,
    input wire logic rstn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [isic_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [isic_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [isic_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [isic_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic wr_en,
    output logic [isic_pkg::ADDR_W-1:0] wr_addr,
    output logic [isic_pkg::DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic [isic_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [isic_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_hit
);
    isic_pkg::isic_wstate_type wst_reg, wst_next;
    isic_pkg::isic_rstate_type rst_reg, rst_next;
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic awready_reg, awready_next, wready_reg, wready_next;
    logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [isic_pkg::ADDR_W-1:0] waddr_reg, waddr_next, raddr_reg, raddr_next;
    logic [isic_pkg::DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    always_comb begin
        wst_next = wst_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        unique case (wst_reg)
            isic_pkg::WST_COLLECT: begin
                if (awvalid && awready_reg) begin
                    aw_have_next = 1'b1;
                    waddr_next = awaddr;
                end
                if (wvalid && wready_reg) begin
                    w_have_next = 1'b1;
                    wdata_next = wdata;
                    wstrb_next = wstrb;
                end
                if (aw_have_next && w_have_next) begin
                    wst_next = isic_pkg::WST_COMMIT;
                end
            end
            isic_pkg::WST_COMMIT: begin
                bresp_next = wr_hit ? isic_pkg::RESP_OKAY : isic_pkg::RESP_SLVERR;
                bvalid_next = 1'b1;
                aw_have_next = 1'b0;
                w_have_next = 1'b0;
                wst_next = isic_pkg::WST_RESP;
            end
            isic_pkg::WST_RESP: begin
                if (bready) begin
                    bvalid_next = 1'b0;
                    wst_next = isic_pkg::WST_COLLECT;
                end
            end
            default: begin
                wst_next = isic_pkg::WST_COLLECT;
            end
        endcase
        awready_next = (wst_next == isic_pkg::WST_COLLECT) && !aw_have_next;
        wready_next = (wst_next == isic_pkg::WST_COLLECT) && !w_have_next;
    end
    always_comb begin
        rst_next = rst_reg;
        raddr_next = raddr_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        rvalid_next = rvalid_reg;
        unique case (rst_reg)
            isic_pkg::RST_IDLE: begin
                if (arvalid && arready_reg) begin
                    raddr_next = araddr;
                    rst_next = isic_pkg::RST_FETCH;
                end
            end
            isic_pkg::RST_FETCH: begin
                rdata_next = rd_hit ? rd_data : '0;
                rresp_next = rd_hit ? isic_pkg::RESP_OKAY : isic_pkg::RESP_SLVERR;
                rvalid_next = 1'b1;
                rst_next = isic_pkg::RST_RESP;
            end
            isic_pkg::RST_RESP: begin
                if (rready) begin
                    rvalid_next = 1'b0;
                    rst_next = isic_pkg::RST_IDLE;
                end
            end
            default: begin
                rst_next = isic_pkg::RST_IDLE;
            end
        endcase
        arready_next = (rst_next == isic_pkg::RST_IDLE);
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wst_reg <= isic_pkg::WST_COLLECT;
            rst_reg <= isic_pkg::RST_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            arready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            bresp_reg <= isic_pkg::RESP_OKAY;
            rresp_reg <= isic_pkg::RESP_OKAY;
            waddr_reg <= '0;
            raddr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            wst_reg <= wst_next;
            rst_reg <= rst_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            bvalid_reg <= bvalid_next;
            rvalid_reg <= rvalid_next;
            bresp_reg <= bresp_next;
            rresp_reg <= rresp_next;
            waddr_reg <= waddr_next;
            raddr_reg <= raddr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            wstrb_reg <= wstrb_next;
        end
    end
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign wr_en = (wst_reg == isic_pkg::WST_COMMIT);
    assign wr_addr = waddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign rd_addr = raddr_reg;
endmodule // isic_axil_slave

// [design/isic_top.sv]
`timescale 1ns/10ps
module isic_top (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [isic_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [isic_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [isic_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [isic_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic MASTER_ROLE_FLAG,
    input wire logic DIRECTION_FLAG,
    input wire logic BUS_OCCUPIED_FLAG,
    input wire logic CHANNEL_INTERRUPT,
    input wire logic ARB_LOST_SET,
    input wire logic OWN_ADDRESS_HIT_SET,
    input wire logic GENERAL_CALL_SET,
    input wire logic DETECT_CLEAR,
    input wire logic LAST_RX_BIT,
    input wire logic CLOCK_SYNC_SERIAL_MODE,
    input wire logic IDLE_MODE,
    output logic [isic_pkg::REG_W-1:0] CONTROL_REGISTER_TWO,
    output logic CONTROL_TWO_WRITE,
    output logic RUN_IN_IDLE,
    output logic CHANNEL_ENABLE,
    output logic IRQ
);
    logic wr_en;
    logic [isic_pkg::ADDR_W-1:0] wr_addr;
    logic [isic_pkg::DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [isic_pkg::ADDR_W-1:0] rd_addr;
    logic [isic_pkg::DATA_W-1:0] rd_data;
    logic rd_hit;

    logic [isic_pkg::ADDR_W-1:0] wr_word;
    logic [isic_pkg::ADDR_W-1:0] rd_word;
    logic wr_low;
    logic wr_status;
    logic wr_rate;
    logic wr_irq_stat;
    logic wr_irq_mask;

    logic [isic_pkg::DET_W-1:0] det_set;
    logic [isic_pkg::DET_W-1:0] det_flags;
    logic [isic_pkg::IRQ_W-1:0] irq_set;
    logic [isic_pkg::IRQ_W-1:0] irq_clr;
    logic [isic_pkg::IRQ_W-1:0] irq_flags;

    logic [isic_pkg::REG_W-1:0] status_word;
    logic [isic_pkg::REG_W-1:0] rate_word;
    logic [isic_pkg::REG_W-1:0] ctrl2_reg;
    logic [isic_pkg::REG_W-1:0] ctrl2_next;
    logic ctrl2_we_reg;
    logic ctrl2_we_next;
    logic run_idle_reg;
    logic run_idle_next;
    logic [isic_pkg::CFG_W-1:0] cfg_reg;
    logic [isic_pkg::CFG_W-1:0] cfg_next;
    logic [isic_pkg::IRQ_W-1:0] mask_reg;
    logic [isic_pkg::IRQ_W-1:0] mask_next;

    logic master_reg;
    logic master_next;
    logic dir_reg;
    logic dir_next;
    logic busy_reg;
    logic busy_next;
    logic intmon_reg;
    logic intmon_next;
    logic lrb_reg;
    logic lrb_next;
    logic int_req_d_reg;
    logic int_req_d_next;
    logic irq_reg;
    logic irq_next;
    logic chan_en_reg;
    logic chan_en_next;

    isic_axil_slave u_bus (
        .clk(CLOCK),
        .rstn(RSTN),
        .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY),
        .awaddr(S_AXI_AWADDR),
        .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY),
        .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB),
        .bvalid(S_AXI_BVALID),
        .bready(S_AXI_BREADY),
        .bresp(S_AXI_BRESP),
        .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY),
        .araddr(S_AXI_ARADDR),
        .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // Protection bits carry no meaning here; every access is treated alike.
    always_comb begin
        wr_word = wr_addr & isic_pkg::WORD_MASK;
        rd_word = rd_addr & isic_pkg::WORD_MASK;
        wr_hit = (wr_word == isic_pkg::OFF_STATUS)
            || (wr_word == isic_pkg::OFF_RATE)
            || (wr_word == isic_pkg::OFF_IRQ_STAT)
            || (wr_word == isic_pkg::OFF_IRQ_MASK);
        rd_hit = (rd_word == isic_pkg::OFF_STATUS)
            || (rd_word == isic_pkg::OFF_RATE)
            || (rd_word == isic_pkg::OFF_IRQ_STAT)
            || (rd_word == isic_pkg::OFF_IRQ_MASK);
        // upper lanes ignored.
        // Only byte lane 0 holds register bits; upper lanes are dropped.
        wr_low = wr_en && wr_strb[0];
        // status write steering.
        // Status address write is steered away from the status flags.
        wr_status = wr_low && (wr_word == isic_pkg::OFF_STATUS);
        wr_rate = wr_low && (wr_word == isic_pkg::OFF_RATE);
        wr_irq_stat = wr_low && (wr_word == isic_pkg::OFF_IRQ_STAT);
        wr_irq_mask = wr_low && (wr_word == isic_pkg::OFF_IRQ_MASK);
    end

    // Detection flags set and hold.
    always_comb begin
        det_set = '0;
        det_set[isic_pkg::DET_ARB] = ARB_LOST_SET;
        det_set[isic_pkg::DET_AAS] = OWN_ADDRESS_HIT_SET;
        det_set[isic_pkg::DET_GC] = GENERAL_CALL_SET;
    end

    isic_flag_bank #(
        .WIDTH(isic_pkg::DET_W)
    ) u_detect (
        .clk(CLOCK),
        .rstn(RSTN),
        .set(det_set),
        .clr({isic_pkg::DET_W{DETECT_CLEAR}}),
        .flags(det_flags)
    );

    // Interrupt events, cleared by writing one.
    always_comb begin
        irq_set = '0;
        irq_set[isic_pkg::IRQ_ARB] = ARB_LOST_SET;
        irq_set[isic_pkg::IRQ_AAS] = OWN_ADDRESS_HIT_SET;
        irq_set[isic_pkg::IRQ_GC] = GENERAL_CALL_SET;
        irq_set[isic_pkg::IRQ_CHAN] = CHANNEL_INTERRUPT && !int_req_d_reg;
        irq_clr = wr_irq_stat ? wr_data[isic_pkg::IRQ_W-1:0] : '0;
    end

    isic_flag_bank #(
        .WIDTH(isic_pkg::IRQ_W)
    ) u_irq (
        .clk(CLOCK),
        .rstn(RSTN),
        .set(irq_set),
        .clr(irq_clr),
        .flags(irq_flags)
    );

    always_comb begin
        status_word = '0;
        // status monitor bits.
        // Live monitors for role, direction, bus and request.
        status_word[isic_pkg::ST_MASTER] = master_reg;
        status_word[isic_pkg::ST_DIR] = dir_reg;
        status_word[isic_pkg::ST_BUSY] = busy_reg;
        status_word[isic_pkg::ST_INTMON] = intmon_reg;
        // detection status bits.
        // Detection and last bit.
        status_word[isic_pkg::ST_ARB] = det_flags[isic_pkg::DET_ARB];
        status_word[isic_pkg::ST_AAS] = det_flags[isic_pkg::DET_AAS];
        status_word[isic_pkg::ST_GC] = det_flags[isic_pkg::DET_GC];
        status_word[isic_pkg::ST_LRB] = lrb_reg;

        rate_word = '0;
        rate_word[isic_pkg::RATE_ONE] = 1'b1;
        // serial mode override.
        // Serial mode forces idle bit in the read value only; RUN_IN_IDLE and channel gating ignore it.
        rate_word[isic_pkg::RATE_RUN] = run_idle_reg | CLOCK_SYNC_SERIAL_MODE;
        rate_word[isic_pkg::CFG_W-1:0] = cfg_reg;

        // upper bits zero.
        // Upper bits zero on read.
        rd_data = '0;
        if (rd_word == isic_pkg::OFF_STATUS) begin
            rd_data[isic_pkg::REG_W-1:0] = status_word;
        end else if (rd_word == isic_pkg::OFF_RATE) begin
            rd_data[isic_pkg::REG_W-1:0] = rate_word;
        end else if (rd_word == isic_pkg::OFF_IRQ_STAT) begin
            rd_data[isic_pkg::IRQ_W-1:0] = irq_flags;
        end else if (rd_word == isic_pkg::OFF_IRQ_MASK) begin
            rd_data[isic_pkg::IRQ_W-1:0] = mask_reg;
        end
    end

    always_comb begin
        master_next = MASTER_ROLE_FLAG;
        dir_next = DIRECTION_FLAG;
        busy_next = BUS_OCCUPIED_FLAG;
        // Request monitor reads zero while a request stands.
        intmon_next = !CHANNEL_INTERRUPT;
        lrb_next = LAST_RX_BIT;
        int_req_d_next = CHANNEL_INTERRUPT;

        // control two update.
        // Control register two write.
        ctrl2_next = wr_status ? wr_data[isic_pkg::REG_W-1:0] : ctrl2_reg;
        ctrl2_we_next = wr_status;
        // idle run bit.
        // Idle run setting write.
        run_idle_next = wr_rate ? wr_data[isic_pkg::RATE_RUN] : run_idle_reg;
        // Low field kept as written; software is expected to store zero there.
        cfg_next = wr_rate ? wr_data[isic_pkg::CFG_W-1:0] : cfg_reg;

        mask_next = wr_irq_mask ? wr_data[isic_pkg::IRQ_W-1:0] : mask_reg;
        irq_next = |(irq_flags & mask_reg);
        // idle stop gating.
        // Idle stop gating of the channel.
        chan_en_next = !IDLE_MODE || run_idle_reg;
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            master_reg <= 1'b0;
            dir_reg <= 1'b0;
            busy_reg <= 1'b0;
            intmon_reg <= isic_pkg::INTMON_RESET;
            lrb_reg <= 1'b0;
            int_req_d_reg <= 1'b0;
            ctrl2_reg <= isic_pkg::CTRL2_RESET;
            ctrl2_we_reg <= 1'b0;
            run_idle_reg <= isic_pkg::RUN_RESET;
            cfg_reg <= isic_pkg::CFG_RESET;
            mask_reg <= isic_pkg::MASK_RESET;
            irq_reg <= 1'b0;
            chan_en_reg <= 1'b1;
        end else begin
            master_reg <= master_next;
            dir_reg <= dir_next;
            busy_reg <= busy_next;
            intmon_reg <= intmon_next;
            lrb_reg <= lrb_next;
            int_req_d_reg <= int_req_d_next;
            ctrl2_reg <= ctrl2_next;
            ctrl2_we_reg <= ctrl2_we_next;
            run_idle_reg <= run_idle_next;
            cfg_reg <= cfg_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            chan_en_reg <= chan_en_next;
        end
    end

    assign CONTROL_REGISTER_TWO = ctrl2_reg;
    assign CONTROL_TWO_WRITE = ctrl2_we_reg;
    assign RUN_IN_IDLE = run_idle_reg;
    assign CHANNEL_ENABLE = chan_en_reg;
    assign IRQ = irq_reg;
endmodule // isic_top

// [testbench/isic_props.sv]
`timescale 1ns/10ps
module isic_props (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [isic_pkg::DATA_W-1:0] S_AXI_RDATA,
    input wire logic IDLE_MODE,
    input wire logic [isic_pkg::REG_W-1:0] CONTROL_REGISTER_TWO,
    input wire logic CONTROL_TWO_WRITE,
    input wire logic RUN_IN_IDLE,
    input wire logic CHANNEL_ENABLE,
    input wire logic IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);
    AST_RESET_OUTS: assert property (
        disable iff (1'b0) !RSTN |=> !RUN_IN_IDLE && CHANNEL_ENABLE && !IRQ
        && CONTROL_REGISTER_TWO == 8'h00) else $error("Outputs not at reset values.");
    AST_IDLE_STOP: assert property (
        (IDLE_MODE && !RUN_IN_IDLE) [*2] |-> !CHANNEL_ENABLE)
        else $error("Channel runs in idle.");
    AST_IDLE_RUN: assert property (
        !IDLE_MODE || RUN_IN_IDLE |=> CHANNEL_ENABLE) else $error("Channel stopped.");
    AST_C2_BY_WRITE: assert property (
        $changed(CONTROL_REGISTER_TWO) |-> CONTROL_TWO_WRITE) else $error("Control two moved.");
    AST_C2_WITH_RESP: assert property (
        CONTROL_TWO_WRITE |-> ##[0:1] S_AXI_BVALID) else $error("Control two pulse stray.");
    AST_B_LATENCY: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
        else $error("Write response late.");
    AST_R_LATENCY: assert property (
        S_AXI_ARVALID && S_AXI_ARREADY |-> ##2 S_AXI_RVALID) else $error("Read data late.");
    AST_R_HOLD: assert property (
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("Read data not held.");
    AST_RD_UPPER: assert property (
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000) else $error("Upper bits not zero.");
    COV_C2: cover property (CONTROL_TWO_WRITE);
    COV_IRQ: cover property (IRQ);
    COV_STOP: cover property (IDLE_MODE && !CHANNEL_ENABLE);
endmodule // isic_props
bind isic_top isic_props i_isic_props (
    .CLOCK, .RSTN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
    .S_AXI_RDATA, .IDLE_MODE, .CONTROL_REGISTER_TWO, .CONTROL_TWO_WRITE, .RUN_IN_IDLE,
    .CHANNEL_ENABLE, .IRQ
);

// [testbench/isic_chan_model.sv]
`timescale 1ns/10ps
module isic_chan_model (
    input wire logic clk,
    output logic [6:0] levels,
    output logic [2:0] det_set,
    output logic det_clear
);
    initial begin
        levels = 7'h00;
        det_set = 3'h0;
        det_clear = 1'b0;
    end
    task automatic set_levels(input logic [6:0] v);
        @(posedge clk);
        levels <= v;
    endtask
    task automatic pulse(input logic [2:0] s, input logic c);
        @(posedge clk);
        det_set <= s;
        det_clear <= c;
        @(posedge clk);
        det_set <= 3'h0;
        det_clear <= 1'b0;
    endtask
endmodule // isic_chan_model

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, c2w, run, chen, irq, dclr;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] wdata, rdata, rd, d;
    logic [7:0] awaddr, araddr, c2;
    logic [3:0] wstrb;
    logic [6:0] lv;
    logic [2:0] dset;
    int n_fail, checks;
    isic_chan_model i_isic_chan_model (.clk(clk), .levels(lv), .det_set(dset), .det_clear(dclr));
    isic_top i_isic_top (.CLOCK(clk), .RSTN(rstn), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .MASTER_ROLE_FLAG(lv[6]),
        .DIRECTION_FLAG(lv[5]), .BUS_OCCUPIED_FLAG(lv[4]), .CHANNEL_INTERRUPT(lv[3]),
        .ARB_LOST_SET(dset[2]), .OWN_ADDRESS_HIT_SET(dset[1]), .GENERAL_CALL_SET(dset[0]),
        .DETECT_CLEAR(dclr), .LAST_RX_BIT(lv[2]), .CLOCK_SYNC_SERIAL_MODE(lv[1]),
        .IDLE_MODE(lv[0]), .CONTROL_REGISTER_TWO(c2), .CONTROL_TWO_WRITE(c2w),
        .RUN_IN_IDLE(run), .CHANNEL_ENABLE(chen), .IRQ(irq));
    function automatic logic [31:0] exp_status(input logic [6:0] v, input logic [2:0] t);
        return {24'h000000, v[6:4], ~v[3], t, v[2]};
    endfunction
    function automatic logic [31:0] exp_rate(input logic r, input logic s);
        return {24'h000000, 1'b1, r | s, 6'h00};
    endfunction
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= v;
        wstrb <= 4'hF;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            if (awready) ta = 1'b1;
            if (wready) tw = 1'b1;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
        @(negedge clk);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        v = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
        {wdata, wstrb} = '0;
        void'($urandom(32'h5f80cf2d));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        axi_rd(8'h00, rd, rs);
        `CHK({rs, rd}, {2'h0, 32'h00000010})
        axi_rd(8'h04, rd, rs);
        `CHK({rs, rd}, {2'h0, 32'h00000080})
        `CHK({chen, run, c2}, {1'b1, 1'b0, 8'h00})
        axi_rd(8'h10, rd, rs);
        `CHK({rs, rd}, {isic_pkg::RESP_SLVERR, 32'h0})
        axi_wr(8'h20, 32'h1, rs);
        `CHK(rs, isic_pkg::RESP_SLVERR)
        for (int i = 0; i < 12; i++) begin
            i_isic_chan_model.set_levels(7'($urandom()));
            d = $urandom();
            axi_wr(8'h00, d, rs);
            `CHK({rs, c2}, {2'h0, d[7:0]})
            axi_rd(8'h00, rd, rs);
            `CHK(rd, exp_status(lv, 3'h0))
            // Software keeps the low configuration bits at zero.
            axi_wr(8'h04, {d[31:8], 1'b0, d[0], 6'h00}, rs);
            axi_rd(8'h04, rd, rs);
            `CHK(rd, exp_rate(d[0], lv[1]))
            `CHK({run, chen}, {d[0], !lv[0] || d[0]})
        end
        for (int i = 0; i < 3; i++) begin
            i_isic_chan_model.pulse(3'(1 << i), 1'b0);
            axi_rd(8'h00, rd, rs);
            `CHK(rd, exp_status(lv, 3'(1 << i)))
            i_isic_chan_model.pulse(3'h0, 1'b1);
            axi_rd(8'h00, rd, rs);
            `CHK(rd, exp_status(lv, 3'h0))
        end
        i_isic_chan_model.pulse(3'h7, 1'b1);
        axi_rd(8'h00, rd, rs);
        `CHK(rd, exp_status(lv, 3'h7))
        axi_wr(8'h08, 32'hF, rs);
        axi_wr(8'h0C, 32'h0, rs);
        i_isic_chan_model.pulse(3'h1, 1'b0);
        axi_rd(8'h08, rd, rs);
        `CHK({rd, irq}, {32'h4, 1'b0})
        axi_wr(8'h0C, 32'h4, rs);
        `CHK(irq, 1'b1)
        axi_wr(8'h08, 32'h4, rs);
        `CHK(irq, 1'b0)
        i_isic_chan_model.set_levels(lv & 7'h77);
        i_isic_chan_model.set_levels(lv | 7'h08);
        axi_rd(8'h08, rd, rs);
        `CHK(rd, 32'h8)
        tally_and_finish();
    end
endmodule // tb_top
